// [core/ffr_pkg.sv]
package ffr_pkg;
	// Instruction codes
	localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
	localparam logic [7:0] OP_WRDI = 8'h04;
	localparam logic [7:0] OP_FUNC_WRITE = 8'h42;
	localparam logic [7:0] OP_RDFR = 8'h48;
	localparam logic [7:0] OP_PARAM_SET_PERSIST = 8'h65;
	localparam logic [7:0] OP_PARAM_SET_TEMP_A = 8'hc0;
	localparam logic [7:0] OP_PARAM_SET_TEMP_B = 8'h63;
	localparam logic [7:0] OP_RDRP = 8'h61;
	// Function register fields
	localparam int FR_RSTDIS = 0;
	localparam int FR_TOP_BOTTOM = 1;
	localparam int FR_PROG_SUSP = 2;
	localparam int FR_ERASE_SUSP = 3;
	localparam int FR_ROW_LOCK0 = 4;
	localparam logic [7:0] FR_OTP_MASK = 8'hf3;
	localparam logic [7:0] FR_RESET = 8'h00;
	// Read parameter fields
	localparam int RP_PIN = 7;
	localparam int RP_DUM_MSB = 6;
	localparam int RP_DUM_LSB = 3;
	localparam int RP_WRAP = 2;
	localparam logic [7:0] RP_RESET = 8'h00;
	// Default dummy counts when the field is zero
	localparam logic [3:0] DUM_FAST_SPI = 4'h8;
	localparam logic [3:0] DUM_QUAD = 4'h6;
	localparam logic [3:0] DUM_DUAL_IO = 4'h4;
	// Base burst size in bytes, shifted left by the two burst bits
	localparam logic [6:0] BURST_BASE = 7'h08;
endpackage

// [core/ffr_sync.sv]
`timescale 1ns/1ns
`default_nettype none
module ffr_sync #(
	parameter int W = 3
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] q;
	} ffr_sync_type;
	ffr_sync_type st_r, st_nxt;
	integer i;
	always_comb begin
		st_nxt = st_r;
		st_nxt.s1 = d;
		st_nxt.s2 = st_r.s1;
		st_nxt.s3 = st_r.s2;
		// A change counts only once stage two and three agree
		for (i = 0; i < W; i++) begin
			if (st_r.s2[i] == st_r.s3[i]) begin
				st_nxt.q[i] = st_r.s3[i];
			end
		end
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end
	assign q = st_r.q;
endmodule
`default_nettype wire

// [core/ffr_nvcell.sv]
`timescale 1ns/1ns
`default_nettype none
// Non-volatile byte store; survives the logic reset, only power-on reloads it with INIT
module ffr_nvcell #(
	parameter int W = 8,
	parameter logic [7:0] INIT = 8'h00
) (
	input wire logic clk,
	input wire logic por_n,
	input wire logic wr,
	input wire logic [W-1:0] wdata,
	input wire logic [W-1:0] keep_mask,
	output logic [W-1:0] rdata
);
	typedef struct packed {
		logic [W-1:0] mem;
	} ffr_nvcell_type;
	ffr_nvcell_type st_r, st_nxt;
	always_comb begin
		st_nxt = st_r;
		// Bits in keep_mask can only be set, never cleared
		if (wr) begin
			st_nxt.mem = (wdata & ~keep_mask) | ((st_r.mem | wdata) & keep_mask);
		end
	end
	always_ff @(posedge clk or negedge por_n) begin
		if (!por_n) begin
			st_r <= INIT[W-1:0];
		end else begin
			st_r <= st_nxt;
		end
	end
	assign rdata = st_r.mem;
endmodule
`default_nettype wire

// [core/ffr_top.sv]
`timescale 1ns/1ns
`default_nettype none
// Function
// - Eight-bit function register with fixed fields
// - Programmed one-time bits never return zero
// - Reset-disable default per variant; moves reset
// - Top/bottom select, bottom is permanent
// - Program suspend flag set/cleared by hardware
// - Erase suspend flag set/cleared by hardware
// - Row lock bits block row programming
// - Volatile read params loaded from persistent copy
// - Pin bit picks hold or reset
// - Quad or four-lane mode makes pin data
// - Dedicated reset variant forces hold function while reset-disable bit is clear
// - Four-bit dummy cycle count field
// - Burst length 8/16/32/64 bytes encoding
// - Wrap enable selects burst or array wrap
// - 65h persistent, C0h/63h temporary copy only
// - Zero dummy field gives command default
// - Write enable required for 42h and 65h
// - Temporary parameter write needs no enable
// - Quad enable turns pins into lanes
module ffr_top #(
	parameter logic RSTDIS_DEFAULT = 1'b0,
	parameter logic HAS_DEDICATED_RESET = 1'b1
) (
	input wire logic CLK,
	input wire logic RESET_N,
	input wire logic POR_N,
	input wire logic CE_N,
	input wire logic SCK,
	input wire logic SI,
	output logic SO,
	output logic SO_OE_N,
	input wire logic FOUR_LANE_ENABLE,
	input wire logic FOUR_LANE_COMMAND_MODE,
	input wire logic PROGRAM_SUSPEND,
	input wire logic ERASE_SUSPEND,
	input wire logic PROGRAM_RESUME,
	input wire logic ERASE_RESUME,
	input wire logic [1:0] INFO_ROW_SEL,
	output logic INFO_ROW_PROGRAM_OK,
	output logic PROTECT_AT_BOTTOM,
	output logic SHARED_PIN_IS_RESET,
	output logic SHARED_PIN_IS_DATA,
	output logic WP_PIN_IS_DATA,
	output logic DEDICATED_RESET_ACTIVE,
	output logic [3:0] DUMMY_FAST_SPI,
	output logic [3:0] DUMMY_QUAD,
	output logic [3:0] DUMMY_DUAL_IO,
	output logic WRAP_AT_BURST,
	output logic [6:0] BURST_BYTES,
	output logic WRITE_ENABLE_LATCH,
	output logic [7:0] FUNCTION_REG,
	output logic [7:0] READ_PARAM_REG
);
	// ----------------------------------------
	// Reset release and pin sampling
	// ----------------------------------------
	logic [1:0] rst_sync_r;
	logic rst_n;
	logic [2:0] pins_q;
	logic ce_n_s, sck_s, si_s;
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			rst_sync_r <= 2'h0;
		end else begin
			rst_sync_r <= {rst_sync_r[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_r[1];
	ffr_sync #(.W(3)) u_sync (
		.clk(CLK),
		.rst_n(rst_n),
		.d({~CE_N, SCK, SI}),
		.q(pins_q)
	);
	assign ce_n_s = ~pins_q[2];
	assign sck_s = pins_q[1];
	assign si_s = pins_q[0];

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef enum {ST_IDLE, ST_OPCODE, ST_DATA, ST_READ, ST_DONE} ffr_phase_type;
	typedef struct packed {
		ffr_phase_type phase;
		logic sck_d;
		logic [2:0] bitcnt;
		logic [7:0] shift;
		logic [7:0] opcode;
		logic [7:0] tx;
		logic so;
		logic so_en;
		logic we_latch;
		logic prog_susp;
		logic erase_susp;
		logic [7:0] rp_vol;
		logic loaded;
		logic has_byte;
	} ffr_state_type;
	ffr_state_type st_r, st_nxt;

	// Persistent copies
	logic fr_wr, rp_nv_wr;
	logic [7:0] fr_wdata, fr_nv, rp_nv;
	ffr_nvcell #(.W(8), .INIT({7'h00, RSTDIS_DEFAULT})) u_fr_nv (
		.clk(CLK),
		.por_n(POR_N),
		.wr(fr_wr),
		.wdata(fr_wdata),
		.keep_mask(ffr_pkg::FR_OTP_MASK),
		.rdata(fr_nv)
	);
	ffr_nvcell #(.W(8), .INIT(ffr_pkg::RP_RESET)) u_rp_nv (
		.clk(CLK),
		.por_n(POR_N),
		.wr(rp_nv_wr),
		.wdata(st_r.shift),
		.keep_mask(8'h00),
		.rdata(rp_nv)
	);

	logic [7:0] fr_view;
	always_comb begin
		fr_view = fr_nv & ffr_pkg::FR_OTP_MASK;
		fr_view[ffr_pkg::FR_PROG_SUSP] = st_r.prog_susp;
		fr_view[ffr_pkg::FR_ERASE_SUSP] = st_r.erase_susp;
	end

	function automatic logic is_param_temp(input logic [7:0] op);
		return (op == ffr_pkg::OP_PARAM_SET_TEMP_A) || (op == ffr_pkg::OP_PARAM_SET_TEMP_B);
	endfunction

	// ----------------------------------------
	// Instruction decode and register update
	// ----------------------------------------
	logic sck_rise, sck_fall, byte_done;
	assign sck_rise = sck_s & ~st_r.sck_d;
	assign sck_fall = ~sck_s & st_r.sck_d;
	assign byte_done = sck_rise && (st_r.bitcnt == 3'h7);
	always_comb begin
		st_nxt = st_r;
		fr_wr = 1'b0;
		fr_wdata = {st_r.shift[7:1], si_s};
		rp_nv_wr = 1'b0;
		st_nxt.sck_d = sck_s;
		if (!st_r.loaded) begin
			st_nxt.rp_vol = rp_nv;
			st_nxt.loaded = 1'b1;
		end
		// Set wins over clear for the suspend flags
		if (PROGRAM_RESUME) st_nxt.prog_susp = 1'b0;
		if (PROGRAM_SUSPEND) st_nxt.prog_susp = 1'b1;
		if (ERASE_RESUME) st_nxt.erase_susp = 1'b0;
		if (ERASE_SUSPEND) st_nxt.erase_susp = 1'b1;
		if (ce_n_s) begin
			st_nxt.phase = ST_IDLE;
			st_nxt.so_en = 1'b0;
			// A frame with no data byte must not commit the opcode as data
			if (st_r.phase == ST_DATA && st_r.bitcnt == 3'h0 && st_r.loaded && st_r.has_byte) begin
				// Commit at deselect after a whole data byte
				unique case (1'b1)
					st_r.opcode == ffr_pkg::OP_FUNC_WRITE: begin
						if (st_r.we_latch) begin
							fr_wdata = st_r.shift;
							fr_wr = 1'b1;
							st_nxt.we_latch = 1'b0;
						end
					end
					st_r.opcode == ffr_pkg::OP_PARAM_SET_PERSIST: begin
						if (st_r.we_latch) begin
							rp_nv_wr = 1'b1;
							st_nxt.we_latch = 1'b0;
						end
					end
					is_param_temp(st_r.opcode): begin
						st_nxt.rp_vol = st_r.shift;
					end
					default: begin
					end
				endcase
			end
		end else begin
			if (st_r.phase == ST_IDLE) begin
				st_nxt.phase = ST_OPCODE;
				st_nxt.bitcnt = 3'h0;
				st_nxt.has_byte = 1'b0;
			end
			if (sck_rise && st_r.phase != ST_DONE) begin
				st_nxt.shift = {st_r.shift[6:0], si_s};
				st_nxt.bitcnt = st_r.bitcnt + 3'h1;
			end
			if (byte_done && st_r.phase == ST_OPCODE) begin
				st_nxt.opcode = {st_r.shift[6:0], si_s};
				st_nxt.phase = ST_DONE;
				unique case ({st_r.shift[6:0], si_s})
					ffr_pkg::OP_WRITE_ENABLE: st_nxt.we_latch = 1'b1;
					ffr_pkg::OP_WRDI: st_nxt.we_latch = 1'b0;
					ffr_pkg::OP_FUNC_WRITE, ffr_pkg::OP_PARAM_SET_PERSIST,
					ffr_pkg::OP_PARAM_SET_TEMP_A,
					ffr_pkg::OP_PARAM_SET_TEMP_B: st_nxt.phase = ST_DATA;
					ffr_pkg::OP_RDFR: begin
						st_nxt.phase = ST_READ;
						st_nxt.tx = fr_view;
					end
					ffr_pkg::OP_RDRP: begin
						st_nxt.phase = ST_READ;
						st_nxt.tx = st_r.rp_vol;
					end
					default: begin
					end
				endcase
			end
			if (byte_done && st_r.phase == ST_DATA) begin
				st_nxt.has_byte = 1'b1;
			end
			// Further data bytes keep the last one; extras just roll in
			if (st_r.phase == ST_READ && sck_fall) begin
				st_nxt.so = st_r.tx[7];
				st_nxt.so_en = 1'b1;
				st_nxt.tx = {st_r.tx[6:0], st_r.tx[7]};
			end
		end
	end
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= '{phase: ST_IDLE, rp_vol: ffr_pkg::RP_RESET, default: '0};
		end else begin
			st_r <= st_nxt;
		end
	end

	// ----------------------------------------
	// Derived controls
	// ----------------------------------------
	logic quad_pins, rstdis;
	logic [3:0] dum_field;
	assign quad_pins = FOUR_LANE_ENABLE | FOUR_LANE_COMMAND_MODE;
	assign rstdis = fr_nv[ffr_pkg::FR_RSTDIS];
	assign dum_field = st_r.rp_vol[ffr_pkg::RP_DUM_MSB:ffr_pkg::RP_DUM_LSB];
	function automatic logic [3:0] dummy_or(input logic [3:0] f, input logic [3:0] dflt);
		return (f == 4'h0) ? dflt : f;
	endfunction
	always_comb begin
		SHARED_PIN_IS_DATA = quad_pins;
		WP_PIN_IS_DATA = FOUR_LANE_ENABLE | FOUR_LANE_COMMAND_MODE;
		// Dedicated reset stays live until the bit is programmed
		DEDICATED_RESET_ACTIVE = HAS_DEDICATED_RESET & ~rstdis;
		if (quad_pins || (HAS_DEDICATED_RESET && !rstdis)) begin
			SHARED_PIN_IS_RESET = 1'b0;
		end else begin
			SHARED_PIN_IS_RESET = st_r.rp_vol[ffr_pkg::RP_PIN];
		end
	end
	assign DUMMY_FAST_SPI = dummy_or(dum_field, ffr_pkg::DUM_FAST_SPI);
	assign DUMMY_QUAD = dummy_or(dum_field, ffr_pkg::DUM_QUAD);
	assign DUMMY_DUAL_IO = dummy_or(dum_field, ffr_pkg::DUM_DUAL_IO);
	assign WRAP_AT_BURST = st_r.rp_vol[ffr_pkg::RP_WRAP];
	assign BURST_BYTES = ffr_pkg::BURST_BASE << st_r.rp_vol[1:0];
	assign INFO_ROW_PROGRAM_OK = ~fr_nv[ffr_pkg::FR_ROW_LOCK0 + int'(INFO_ROW_SEL)];
	assign PROTECT_AT_BOTTOM = fr_nv[ffr_pkg::FR_TOP_BOTTOM];
	assign WRITE_ENABLE_LATCH = st_r.we_latch;
	assign FUNCTION_REG = fr_view;
	assign READ_PARAM_REG = st_r.rp_vol;
	assign SO = st_r.so;
	assign SO_OE_N = ~st_r.so_en;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_otp_sticky: assert property (@(posedge CLK) disable iff (!rst_n || !POR_N)
		!fr_wr |=> $stable(fr_nv))
		else $error("one-time bits changed without a write");
	a_otp_never_clear: assert property (@(posedge CLK) disable iff (!rst_n || !POR_N)
		(($past(fr_nv) & ffr_pkg::FR_OTP_MASK & ~fr_nv) == 8'h00))
		else $error("otp bit returned to zero");
	a_prog_susp_set: assert property (@(posedge CLK) disable iff (!rst_n)
		PROGRAM_SUSPEND |=> FUNCTION_REG[ffr_pkg::FR_PROG_SUSP])
		else $error("program suspend flag not set");
	a_erase_susp_clear: assert property (@(posedge CLK) disable iff (!rst_n)
		ERASE_RESUME && !ERASE_SUSPEND |=> !FUNCTION_REG[ffr_pkg::FR_ERASE_SUSP])
		else $error("erase suspend flag not cleared");
	a_func_write_enable: assert property (@(posedge CLK) disable iff (!rst_n)
		fr_wr |-> st_r.we_latch)
		else $error("function write without enable");
	a_persist_write_enable: assert property (@(posedge CLK) disable iff (!rst_n)
		rp_nv_wr |-> st_r.we_latch ##1 !st_r.we_latch)
		else $error("persistent write without enable");
	a_pin_quad: assert property (@(posedge CLK) disable iff (!rst_n)
		quad_pins |-> SHARED_PIN_IS_DATA && !SHARED_PIN_IS_RESET)
		else $error("shared pin not data in quad");
	a_pin_dedicated: assert property (@(posedge CLK) disable iff (!rst_n)
		HAS_DEDICATED_RESET && !rstdis |-> !SHARED_PIN_IS_RESET)
		else $error("shared pin reset despite dedicated pin");
	a_dummy_dflt: assert property (@(posedge CLK) disable iff (!rst_n)
		dum_field == 4'h0 |-> DUMMY_DUAL_IO == ffr_pkg::DUM_DUAL_IO
			&& DUMMY_FAST_SPI == ffr_pkg::DUM_FAST_SPI && DUMMY_QUAD == ffr_pkg::DUM_QUAD)
		else $error("dummy default wrong");
	a_nv_untouched: assert property (@(posedge CLK) disable iff (!rst_n || !POR_N)
		!rp_nv_wr |=> $stable(rp_nv))
		else $error("persistent params changed unexpectedly");
	c_func_write: cover property (@(posedge CLK) fr_wr);
	c_param_temp: cover property (@(posedge CLK) $changed(st_r.rp_vol) && st_r.loaded);
	c_prog_susp: cover property (@(posedge CLK) $rose(st_r.prog_susp));
endmodule
`default_nettype wire

// [tb/ffr_host_model.sv]
`timescale 1ns/1ns
`default_nettype none
module ffr_host_model (
	input wire logic clk,
	output logic ce_n,
	output logic sck,
	output logic si,
	input wire logic so
);
	// --------------------------------
	// Serial frames, mode 0, clock idle low
	// --------------------------------
	initial begin
		ce_n = 1'b1;
		sck = 1'b0;
		si = 1'b0;
	end

	// Opcode, then one data byte if asked; rd holds the byte clocked back on so
	task automatic frame(input logic [7:0] op, input logic has_data, input logic [7:0] data,
			output logic [7:0] rd);
		logic [15:0] sh;
		sh = {op, data};
		rd = 8'h00;
		@(posedge clk);
		ce_n <= 1'b0;
		for (int b = 0; b < (has_data ? 16 : 8); b++) begin
			si <= sh[15];
			sh = {sh[14:0], 1'b0};
			repeat (4) @(posedge clk);
			sck <= 1'b1;
			repeat (3) @(posedge clk);
			// Sampled late in the high phase, well after the output moved
			@(negedge clk);
			rd = {rd[6:0], so};
			@(posedge clk);
			sck <= 1'b0;
		end
		repeat (4) @(posedge clk);
		ce_n <= 1'b1;
		// Released line does not keep its last level
		si <= ~si;
		repeat (12) @(posedge clk);
		@(negedge clk);
	endtask

	task automatic write_reg(input logic [7:0] op, input logic [7:0] data, input logic write_enable_latch);
		logic [7:0] rd;
		if (write_enable_latch) begin
			frame(ffr_pkg::OP_WRITE_ENABLE, 1'b0, 8'h00, rd);
		end
		frame(op, 1'b1, data, rd);
	endtask
endmodule
`default_nettype wire

// [tb/testbench.sv]
`timescale 1ns/1ns
`default_nettype none
module testbench;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic por_n = 1'b0;
	logic lane4_en = 1'b0;
	logic lane4_cmd = 1'b0;
	logic [3:0] ev = 4'h0;
	logic [1:0] row_sel = 2'h0;
	logic ce_n, sck, si, so, row_ok, at_bottom, pin_rst, pin_data, wp_data, ded_rst, wrap;
	logic we_latch, oe_n;
	logic oe_low_seen = 1'b0;
	logic [3:0] d_fast, d_quad, d_dual;
	logic [6:0] burst;
	logic [7:0] fr, rp, rd, v, efr;
	logic [31:0] seed = 32'h5ad9;
	logic [31:0] rnd;
	int mismatches = 0;
	int total_checks = 0;
	int cycles = 0;

	always #25 clk = ~clk;

	ffr_host_model host (.clk(clk), .ce_n(ce_n), .sck(sck), .si(si), .so(so));

	ffr_top #(.RSTDIS_DEFAULT(1'b0), .HAS_DEDICATED_RESET(1'b1)) dut (
		.CLK(clk), .RESET_N(reset_n), .POR_N(por_n), .CE_N(ce_n), .SCK(sck), .SI(si),
		.SO(so), .SO_OE_N(oe_n), .FOUR_LANE_ENABLE(lane4_en),
		.FOUR_LANE_COMMAND_MODE(lane4_cmd),
		.PROGRAM_SUSPEND(ev[0]), .ERASE_SUSPEND(ev[1]), .PROGRAM_RESUME(ev[2]),
		.ERASE_RESUME(ev[3]), .INFO_ROW_SEL(row_sel), .INFO_ROW_PROGRAM_OK(row_ok),
		.PROTECT_AT_BOTTOM(at_bottom), .SHARED_PIN_IS_RESET(pin_rst),
		.SHARED_PIN_IS_DATA(pin_data), .WP_PIN_IS_DATA(wp_data),
		.DEDICATED_RESET_ACTIVE(ded_rst), .DUMMY_FAST_SPI(d_fast), .DUMMY_QUAD(d_quad),
		.DUMMY_DUAL_IO(d_dual), .WRAP_AT_BURST(wrap), .BURST_BYTES(burst),
		.WRITE_ENABLE_LATCH(we_latch), .FUNCTION_REG(fr), .READ_PARAM_REG(rp));

	// --------------------------------
	// Helpers
	// --------------------------------
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	function automatic logic [3:0] dflt(input logic [3:0] f, input logic [3:0] d);
		return (f == 4'h0) ? d : f;
	endfunction

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic check_rp(input logic [7:0] p);
		check(rp, p);
		check(d_fast, dflt(p[6:3], 4'h8));
		check(d_quad, dflt(p[6:3], 4'h6));
		check(d_dual, dflt(p[6:3], 4'h4));
		check(burst, 8'h08 << p[1:0]);
		check(wrap, p[2]);
		check(pin_data, lane4_en | lane4_cmd);
		if (!lane4_cmd) begin
			check(wp_data, lane4_en);
		end
		check(pin_rst, !(lane4_en | lane4_cmd) && p[7] && efr[0]);
	endtask

	task automatic pulse(input logic [3:0] m);
		@(posedge clk);
		ev <= m;
		@(posedge clk);
		ev <= 4'h0;
		repeat (3) @(posedge clk);
		@(negedge clk);
	endtask

	task automatic final_report;
		if (mismatches == 0 && total_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			final_report;
		end
	end

	// Remembers that the output driver was switched on at some point
	always @(posedge clk) begin
		if (oe_n === 1'b0) begin
			oe_low_seen <= 1'b1;
		end
	end

	// --------------------------------
	// Main sequence
	// --------------------------------
	initial begin
		efr = 8'h00;
		repeat (3) @(posedge clk);
		reset_n <= 1'b1;
		por_n <= 1'b1;
		repeat (12) @(posedge clk);
		@(negedge clk);
		check(fr, 8'h00);
		check(ded_rst, 1'b1);
		check(oe_n, 1'b1);
		check_rp(8'h00);
		for (int i = 0; i < 8; i++) begin
			rnd = xs();
			v = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : rnd[7:0];
			@(posedge clk);
			lane4_en <= rnd[8];
			lane4_cmd <= rnd[9] & rnd[10];
			host.write_reg(i[0] ? ffr_pkg::OP_PARAM_SET_TEMP_A : ffr_pkg::OP_PARAM_SET_TEMP_B,
				v, 1'b0);
			check_rp(v);
			check(we_latch, 1'b0);
			check(oe_low_seen, i != 0);
			host.frame(ffr_pkg::OP_RDRP, 1'b1, 8'h00, rd);
			check(rd, v);
			check(oe_n, 1'b1);
			check(oe_low_seen, 1'b1);
		end
		@(posedge clk);
		lane4_en <= 1'b0;
		lane4_cmd <= 1'b0;
		host.write_reg(ffr_pkg::OP_PARAM_SET_PERSIST, 8'h9d, 1'b1);
		check(we_latch, 1'b0);
		check_rp(v);
		host.write_reg(ffr_pkg::OP_PARAM_SET_PERSIST, 8'h5a, 1'b0);
		@(posedge clk);
		reset_n <= 1'b0;
		repeat (3) @(posedge clk);
		reset_n <= 1'b1;
		repeat (12) @(posedge clk);
		@(negedge clk);
		check_rp(8'h9d);
		host.frame(ffr_pkg::OP_WRITE_ENABLE, 1'b0, 8'h00, rd);
		check(we_latch, 1'b1);
		host.frame(ffr_pkg::OP_WRDI, 1'b0, 8'h00, rd);
		check(we_latch, 1'b0);
		host.write_reg(ffr_pkg::OP_FUNC_WRITE, 8'hff, 1'b0);
		check(fr, 8'h00);
		host.frame(ffr_pkg::OP_WRITE_ENABLE, 1'b0, 8'h00, rd);
		host.frame(ffr_pkg::OP_FUNC_WRITE, 1'b0, 8'h00, rd);
		check(fr, 8'h00);
		check(we_latch, 1'b1);
		host.write_reg(ffr_pkg::OP_FUNC_WRITE, 8'h17, 1'b1);
		efr = 8'h13;
		check(fr, efr);
		check(at_bottom, 1'b1);
		check(ded_rst, 1'b0);
		check_rp(8'h9d);
		for (int r = 0; r < 4; r++) begin
			@(posedge clk);
			row_sel <= r[1:0];
			@(negedge clk);
			check(row_ok, !efr[4 + r]);
		end
		host.write_reg(ffr_pkg::OP_FUNC_WRITE, 8'he0, 1'b1);
		efr = 8'hf3;
		check(fr, efr);
		host.write_reg(ffr_pkg::OP_FUNC_WRITE, 8'h00, 1'b1);
		check(fr, efr);
		host.frame(ffr_pkg::OP_RDFR, 1'b1, 8'h00, rd);
		check(rd, efr);
		pulse(4'h1);
		efr[2] = 1'b1;
		check(fr, efr);
		pulse(4'h2);
		efr[3] = 1'b1;
		check(fr, efr);
		host.write_reg(ffr_pkg::OP_FUNC_WRITE, 8'h00, 1'b1);
		check(fr, efr);
		pulse(4'ha);
		check(fr, efr);
		pulse(4'h4);
		efr[2] = 1'b0;
		check(fr, efr);
		pulse(4'h8);
		efr[3] = 1'b0;
		check(fr, efr);
		final_report;
	end
endmodule
`default_nettype wire
